// ===== logic/esmc_ctrl_pkg.sv
`default_nettype none
package esmc_ctrl_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_NS          = 100;
  localparam int unsigned ESMC_PERIOD_S   = 1;
  localparam int unsigned SP_MAX_PER_S    = 10;
  localparam int unsigned NS_PER_S        = 1000000000;
  localparam int unsigned ESMC_PERIOD_CYC = ESMC_PERIOD_S * NS_PER_S / CLK_NS;
  // Spacing frames evenly keeps every sliding one-second window legal.
  localparam int unsigned SP_GAP_CYC      = ESMC_PERIOD_CYC / SP_MAX_PER_S;
  localparam int unsigned SYNC_DEAD_NS    = 1600;
  localparam int unsigned SYNC_DEAD_CYC   = SYNC_DEAD_NS / CLK_NS;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned DEAD_W          = 5;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  ADDR_PORT0  = 8'h00;
  localparam logic [7:0]  ADDR_PORT1  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_DROPS  = 8'h0c;

  localparam int unsigned CTRL_SYNC   = 0;
  localparam int unsigned CTRL_ESMC   = 1;
  localparam int unsigned CTRL_QL     = 2;
  localparam int unsigned CTRL_TXQL   = 4;
  localparam int unsigned CTRL_W      = 8;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;

  localparam int unsigned STAT_ALIVE  = 0;
  localparam int unsigned STAT_RXQL   = 4;
  localparam int unsigned STAT_ACT    = 16;
  localparam int unsigned STAT_OFFER  = 20;
  localparam int unsigned STAT_TXCLK  = 24;
  localparam int unsigned DROP_W      = 16;

  // ************************************************************
  // Codes
  // ************************************************************
  localparam int unsigned QL_W        = 4;
  localparam logic [3:0]  QL_DNU      = 4'hf;
  localparam logic [47:0] SLOW_DA     = 48'h0180c2000002;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OWN_NONE = 2'b00,
    OWN_P0   = 2'b01,
    OWN_P1   = 2'b10,
    OWN_SP   = 2'b11
  } owner_t;

endpackage
`default_nettype wire

// ===== logic/esmc_port.sv
`timescale 1ns/1ns
`default_nettype none
module esmc_port #(
  parameter int unsigned PERIOD_CYC = esmc_ctrl_pkg::ESMC_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          clkEn,
  // Configuration
  input  wire logic                          syncMode,
  input  wire logic                          esmcOn,
  input  wire logic                          qlOn,
  input  wire logic [esmc_ctrl_pkg::QL_W-1:0] txQlCfg,
  // Transmit
  input  wire logic                          txTaken,
  output logic                               txPending,
  output logic [esmc_ctrl_pkg::QL_W-1:0]     txQl,
  // Receive
  input  wire logic                          rxValid,
  input  wire logic                          rxEsmc,
  input  wire logic [esmc_ctrl_pkg::QL_W-1:0] rxQlIn,
  output logic                               rxPeer,
  output logic                               rxDrop,
  output logic [esmc_ctrl_pkg::QL_W-1:0]     rxQl,
  output logic                               active
);
  import esmc_ctrl_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic             on_q;
  logic             esmcRun;
  logic             qlRun;
  logic             tick;

  assign esmcRun = syncMode & esmcOn;
  assign qlRun   = esmcRun & qlOn;
  assign active  = esmcRun;
  assign tick    = on_q & esmcRun & (cnt_q == CNT_W'(PERIOD_CYC - 1));

  // ************************************************************
  // Pacing
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      on_q <= 1'b0;
    end else if (clkEn) begin
      on_q <= esmcRun;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clkEn) begin
      if (!esmcRun || !on_q || tick) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // A tick in the same cycle as a hand-off keeps the new frame pending.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      txPending <= 1'b0;
    end else if (clkEn) begin
      if (!esmcRun) begin
        txPending <= 1'b0;
      end else if (tick) begin
        txPending <= 1'b1;
      end else if (txTaken) begin
        txPending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      txQl <= QL_DNU;
    end else if (clkEn) begin
      txQl <= qlRun ? txQlCfg : QL_DNU;
    end
  end

  // ************************************************************
  // Receive
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxPeer <= 1'b0;
      rxDrop <= 1'b0;
    end else if (clkEn) begin
      rxPeer <= rxValid & rxEsmc & esmcRun;
      rxDrop <= rxValid & rxEsmc & ~esmcRun;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxQl <= QL_DNU;
    end else if (clkEn) begin
      if (!qlRun) begin
        rxQl <= QL_DNU;
      end else if (rxValid && rxEsmc) begin
        rxQl <= rxQlIn;
      end
    end
  end

endmodule
`default_nettype wire

// ===== logic/esmc_sync_ctrl.sv
// How it works
// - Sync off: full duplex, free clock, messaging off.
// - Sync on: transmit clock from equipment clock.
// - Enabling sync also enables messaging.
// - Messaging on: one frame every second.
// - Slow-protocol frames never exceed ten per second.
// - Frames go to slow-protocol multicast address.
// - Messaging off: no frames generated.
// - Messaging off: arriving frames discarded.
// - Messaging on: transmit path generates frames.
// - Messaging on: received frames go to local process.
// - Sync without messaging still uses equipment clock.
// - Aggregation state never touches timing state.
// - Each link has its own channel and quality.
// - Quality off: send do-not-use, ignore received.
// - Quality on: send and process quality values. Here only while messaging is also on.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module esmc_sync_ctrl #(
  parameter int unsigned ESMC_PERIOD = esmc_ctrl_pkg::ESMC_PERIOD_CYC,
  parameter int unsigned SP_GAP      = esmc_ctrl_pkg::SP_GAP_CYC
) (
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  input  wire logic                            clkEn,
  // AXI4-Lite slave
  input  wire logic [esmc_ctrl_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output logic                                 wready,
  output logic [1:0]                           bresp,
  output logic                                 bvalid,
  input  wire logic                            bready,
  input  wire logic [esmc_ctrl_pkg::ADDR_W-1:0] araddr,
  input  wire logic                            arvalid,
  output logic                                 arready,
  output logic [31:0]                          rdata,
  output logic [1:0]                           rresp,
  output logic                                 rvalid,
  input  wire logic                            rready,
  // Equipment clock pin
  input  wire logic                            syncClkIn,
  // Per-link timing
  output logic [1:0]                           txClkSel,
  output logic [1:0]                           fullDuplex,
  output logic [1:0]                           clkSrcOffer,
  // Transmit requests
  output logic [1:0]                           esmcTxValid,
  input  wire logic [1:0]                      esmcTxReady,
  output logic [2*esmc_ctrl_pkg::QL_W-1:0]     esmcTxQl,
  output logic [47:0]                          slowDstAddr,
  input  wire logic                            spTxReq,
  output logic                                 spTxGrant,
  // Receive
  input  wire logic [1:0]                      rxValid,
  input  wire logic [1:0]                      rxEsmc,
  input  wire logic [2*esmc_ctrl_pkg::QL_W-1:0] rxQlIn,
  output logic [1:0]                           rxPeer,
  output logic [1:0]                           rxDrop
);
  import esmc_ctrl_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Clearing sync mode clears messaging and quality with it, and
  // a fresh sync enable turns messaging on.
  function automatic logic [CTRL_W-1:0] applyCtrl(
    input logic [CTRL_W-1:0] old,
    input logic [CTRL_W-1:0] wd
  );
    logic [CTRL_W-1:0] nv;
    nv = wd;
    if (!wd[CTRL_SYNC]) begin
      nv[CTRL_ESMC] = 1'b0;
      nv[CTRL_QL]   = 1'b0;
    end else if (!old[CTRL_SYNC]) begin
      nv[CTRL_ESMC] = 1'b1;
    end
    return nv;
  endfunction

  function automatic logic [31:0] ctrlWord(input logic [CTRL_W-1:0] c);
    return {24'h000000, c};
  endfunction

  logic [CTRL_W-1:0] ctrl_q [2];
  logic [DROP_W-1:0] drop_q [2];
  logic [1:0]        pend;
  logic [1:0]        active;
  logic [1:0]        taken;
  logic [QL_W-1:0]   rxQlSeen [2];

  // ************************************************************
  // Per-link channels
  // ************************************************************
  // Link aggregation state is deliberately not an input here.
  for (genvar p = 0; p < 2; p++) begin : g_port
    esmc_port #(
      .PERIOD_CYC(ESMC_PERIOD)
    ) u_port (
      .clock    (clock),
      .rst_n    (rst_n),
      .clkEn    (clkEn),
      .syncMode (ctrl_q[p][CTRL_SYNC]),
      .esmcOn   (ctrl_q[p][CTRL_ESMC]),
      .qlOn     (ctrl_q[p][CTRL_QL]),
      .txQlCfg  (ctrl_q[p][CTRL_TXQL +: QL_W]),
      .txTaken  (taken[p]),
      .txPending(pend[p]),
      .txQl     (esmcTxQl[p*QL_W +: QL_W]),
      .rxValid  (rxValid[p]),
      .rxEsmc   (rxEsmc[p]),
      .rxQlIn   (rxQlIn[p*QL_W +: QL_W]),
      .rxPeer   (rxPeer[p]),
      .rxDrop   (rxDrop[p]),
      .rxQl     (rxQlSeen[p]),
      .active   (active[p])
    );

    always_ff @(posedge clock) begin
      if (!rst_n) begin
        txClkSel[p]    <= 1'b0;
        clkSrcOffer[p] <= 1'b1;
      end else if (clkEn) begin
        txClkSel[p]    <= ctrl_q[p][CTRL_SYNC];
        clkSrcOffer[p] <= ~active[p];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fullDuplex  <= 2'b11;
      slowDstAddr <= SLOW_DA;
    end else if (clkEn) begin
      fullDuplex  <= 2'b11;
      slowDstAddr <= SLOW_DA;
    end
  end

  // ************************************************************
  // Slow-protocol transmit arbiter
  // ************************************************************
  owner_t           owner_q;
  logic [CNT_W-1:0] gap_q;
  logic             gapOk;
  logic             anyTaken;

  assign gapOk          = (gap_q == '0);
  assign esmcTxValid[0] = (owner_q == OWN_P0) & pend[0];
  assign esmcTxValid[1] = (owner_q == OWN_P1) & pend[1];
  assign spTxGrant      = (owner_q == OWN_SP);
  assign taken          = esmcTxValid & esmcTxReady;
  assign anyTaken       = (|taken) | spTxGrant;

  // The owner is latched so an offered request never changes under
  // the receiver; a link disabled mid-offer withdraws its request.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      owner_q <= OWN_NONE;
    end else if (clkEn) begin
      case (owner_q)
        OWN_NONE: begin
          if (gapOk && pend[0]) begin
            owner_q <= OWN_P0;
          end else if (gapOk && pend[1]) begin
            owner_q <= OWN_P1;
          end else if (gapOk && spTxReq) begin
            owner_q <= OWN_SP;
          end
        end
        OWN_P0: begin
          if (taken[0] || !pend[0]) begin
            owner_q <= OWN_NONE;
          end
        end
        OWN_P1: begin
          if (taken[1] || !pend[1]) begin
            owner_q <= OWN_NONE;
          end
        end
        OWN_SP: owner_q <= OWN_NONE;
        default: owner_q <= OWN_NONE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gap_q <= '0;
    end else if (clkEn) begin
      if (anyTaken) begin
        gap_q <= CNT_W'(SP_GAP - 1);
      end else if (!gapOk) begin
        gap_q <= gap_q - CNT_W'(1);
      end
    end
  end

  // ************************************************************
  // Equipment clock monitor
  // ************************************************************
  logic              s1_q;
  logic              s2_q;
  logic              s3_q;
  logic              lvl_q;
  logic [DEAD_W-1:0] dead_q;
  logic              syncEdge;
  logic              alive;

  assign syncEdge = (s2_q == s3_q) && (s3_q != lvl_q);
  assign alive    = (dead_q < DEAD_W'(SYNC_DEAD_CYC));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else if (clkEn) begin
      s1_q <= syncClkIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dead_q <= DEAD_W'(SYNC_DEAD_CYC);
    end else if (clkEn) begin
      if (syncEdge) begin
        dead_q <= '0;
      end else if (alive) begin
        dead_q <= dead_q + DEAD_W'(1);
      end
    end
  end

  // ************************************************************
  // AXI4-Lite write path
  // ************************************************************
  logic              awHave_q;
  logic              wHave_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              doWrite;
  logic              wrMapped;

  assign awready  = ~awHave_q & ~bvalid;
  assign wready   = ~wHave_q & ~bvalid;
  assign doWrite  = awHave_q & wHave_q & ~bvalid;
  assign wrMapped = (awAddr_q == ADDR_PORT0) || (awAddr_q == ADDR_PORT1)
                 || (awAddr_q == ADDR_STATUS) || (awAddr_q == ADDR_DROPS);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awHave_q <= 1'b0;
      awAddr_q <= '0;
    end else if (clkEn) begin
      if (awvalid && awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= {awaddr[ADDR_W-1:2], 2'b00};
      end else if (doWrite) begin
        awHave_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wHave_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else if (clkEn) begin
      if (wvalid && wready) begin
        wHave_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end else if (doWrite) begin
        wHave_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (clkEn) begin
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q[0] <= CTRL_RESET;
      ctrl_q[1] <= CTRL_RESET;
    end else if (clkEn && doWrite && wStrb_q[0]) begin
      if (awAddr_q == ADDR_PORT0) begin
        ctrl_q[0] <= applyCtrl(ctrl_q[0], wData_q[CTRL_W-1:0]);
      end
      if (awAddr_q == ADDR_PORT1) begin
        ctrl_q[1] <= applyCtrl(ctrl_q[1], wData_q[CTRL_W-1:0]);
      end
    end
  end

  // Any write to the drop register clears both counters; a discard in
  // the same cycle is still counted.
  logic dropClr;
  assign dropClr = doWrite && (awAddr_q == ADDR_DROPS);

  for (genvar p = 0; p < 2; p++) begin : g_drop
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        drop_q[p] <= '0;
      end else if (clkEn) begin
        if (dropClr) begin
          drop_q[p] <= DROP_W'(rxDrop[p]);
        end else if (rxDrop[p]) begin
          drop_q[p] <= drop_q[p] + DROP_W'(1);
        end
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read path
  // ************************************************************
  logic [31:0] status;
  logic [31:0] rdMux;
  logic        rdMapped;

  always_comb begin
    status                    = '0;
    status[STAT_ALIVE]        = alive;
    status[STAT_RXQL +: QL_W] = rxQlSeen[0];
    status[STAT_RXQL + QL_W +: QL_W] = rxQlSeen[1];
    status[STAT_ACT +: 2]     = active;
    status[STAT_OFFER +: 2]   = clkSrcOffer;
    status[STAT_TXCLK +: 2]   = txClkSel;
  end

  always_comb begin
    rdMapped = 1'b1;
    case ({araddr[ADDR_W-1:2], 2'b00})
      ADDR_PORT0:  rdMux = ctrlWord(ctrl_q[0]);
      ADDR_PORT1:  rdMux = ctrlWord(ctrl_q[1]);
      ADDR_STATUS: rdMux = status;
      ADDR_DROPS:  rdMux = {drop_q[1], drop_q[0]};
      default: begin
        rdMux    = '0;
        rdMapped = 1'b0;
      end
    endcase
  end

  assign arready = ~rvalid;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (clkEn) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rdMux;
        rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== verification/esmc_peer_model.sv
`timescale 1ns/1ns
`default_nettype none
module esmc_peer_model (
  // Clock and control
  input  wire logic        clock,
  input  wire logic        stall,
  // Frames from the block
  input  wire logic [1:0]  esmcTxValid,
  input  wire logic [7:0]  esmcTxQl,
  input  wire logic [47:0] slowDstAddr,
  output logic [1:0]       esmcTxReady,
  // Frames toward the block
  output logic [1:0]       rxValid,
  output logic [1:0]       rxEsmc,
  output logic [7:0]       rxQlIn
);
  import esmc_ctrl_pkg::*;
  int unsigned txCount [2];
  logic [3:0]  lastQl [2];
  logic        badDst = 1'b0;
  initial begin
    rxValid = 2'h0;
    rxEsmc = 2'h0;
    rxQlIn = 8'h0;
  end
  // A stalled peer makes the block keep its request standing.
  assign esmcTxReady = {2{!stall}};
  always @(posedge clock) begin
    for (int p = 0; p < 2; p++) begin
      if (esmcTxValid[p] && esmcTxReady[p]) begin
        txCount[p]++;
        lastQl[p] = esmcTxQl[4*p +: 4];
        if (slowDstAddr !== SLOW_DA) badDst = 1'b1;
      end
    end
  end
  // Between frames the lines carry the inverse, so a stale value fails.
  task sendFrame(input int p, input logic esmc, input logic [3:0] ql);
    @(posedge clock);
    rxValid[p] <= 1'b1;
    rxEsmc[p] <= esmc;
    rxQlIn[4*p +: 4] <= ql;
    @(posedge clock);
    rxValid[p] <= 1'b0;
    rxEsmc[p] <= !esmc;
    rxQlIn[4*p +: 4] <= ~ql;
  endtask
endmodule
`default_nettype wire

// ===== verification/esmc_sync_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module esmc_sync_ctrl_asserts #(
  parameter int unsigned ESMC_PERIOD = 100,
  parameter int unsigned SP_GAP      = 10
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Register bus
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  // Link side
  input wire logic [1:0]  fullDuplex,
  input wire logic [1:0]  clkSrcOffer,
  input wire logic [1:0]  esmcTxValid,
  input wire logic [1:0]  esmcTxReady,
  input wire logic [7:0]  esmcTxQl,
  input wire logic [47:0] slowDstAddr,
  input wire logic        spTxGrant,
  input wire logic [1:0]  rxValid,
  input wire logic [1:0]  rxEsmc,
  input wire logic [1:0]  rxPeer,
  input wire logic [1:0]  rxDrop
);
  import esmc_ctrl_pkg::*;
  logic        take;
  logic [23:0] sinceTake_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ************************************************************
  // Spacing of slow-protocol frames
  // ************************************************************
  assign take = (|(esmcTxValid & esmcTxReady)) | spTxGrant;
  // Saturates so a long idle stretch never wraps into a false short gap.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sinceTake_q <= '1;
    end else if (take) begin
      sinceTake_q <= 24'h1;
    end else if (sinceTake_q != '1) begin
      sinceTake_q <= sinceTake_q + 24'h1;
    end
  end
  chk_take_gap: assert property (take |-> sinceTake_q > SP_GAP)
    else $error("frames sent too close together");
  chk_one_take: assert property (
      $onehot0({esmcTxValid & esmcTxReady, spTxGrant}))
    else $error("two frames taken at once");
  // ************************************************************
  // Link state and register bus handshakes
  // ************************************************************
  chk_duplex_full: assert property (fullDuplex == 2'b11)
    else $error("port left full duplex");
  chk_slow_addr: assert property (slowDstAddr == SLOW_DA)
    else $error("wrong slow-protocol destination");
  chk_offer_off: assert property (
      $rose(esmcTxValid[0]) |-> !clkSrcOffer[0])
    else $error("messaging port offered as source");
  chk_ql_unused: assert property (
      clkSrcOffer[0] && $past(clkSrcOffer[0]) |-> esmcTxQl[3:0] == QL_DNU)
    else $error("quality sent while messaging is off");
  chk_rx_answer: assert property (
      rxValid[0] && rxEsmc[0] |=> rxPeer[0] != rxDrop[0])
    else $error("received frame neither peered nor dropped");
  chk_rx_cause: assert property (
      rxPeer[1] || rxDrop[1] |-> $past(rxValid[1] && rxEsmc[1]))
    else $error("receive pulse without a frame");
  chk_read_next: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_resp_hold: assert property (
      bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
endmodule
bind esmc_sync_ctrl esmc_sync_ctrl_asserts #(
  .ESMC_PERIOD(ESMC_PERIOD),
  .SP_GAP(SP_GAP)
) u_esmc_sync_ctrl_asserts (.*);
`default_nettype wire

// ===== verification/esmc_sync_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module esmc_sync_ctrl_bench;
  import esmc_ctrl_pkg::*;
  localparam int unsigned PER = 100;
  localparam int unsigned GAP = 10;
  logic        clock = 1'b0, rst_n = 1'b0, clkEn = 1'b1, syncClkIn = 1'b0;
  logic        clkRun = 1'b1, stall = 1'b0, spTxReq = 1'b0, spTxGrant;
  logic        awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid;
  logic        bready = 1'b0, arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0, esmcTxQl, rxQlIn;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, wrResp, rdResp, txClkSel, fullDuplex;
  logic [1:0]  clkSrcOffer, esmcTxValid, esmcTxReady;
  logic [1:0]  rxValid, rxEsmc, rxPeer, rxDrop;
  logic [47:0] slowDstAddr;
  int          errors, nTests, cycles, takes, spCnt, peers, drops, s;
  esmc_sync_ctrl #(.ESMC_PERIOD(PER), .SP_GAP(GAP)) u_esmc_sync_ctrl (.*);
  esmc_peer_model u_esmc_peer_model (.*);
  always #50 clock = ~clock;
  // The equipment clock is offset so its edges never meet ours.
  initial begin
    #37;
    forever #400 syncClkIn = clkRun ? ~syncClkIn : syncClkIn;
  end
  always @(posedge clock) begin
    cycles++;
    takes += $countones(esmcTxValid & esmcTxReady) + int'(spTxGrant);
    spCnt += int'(spTxGrant);
    peers += $countones(rxPeer);
    drops += $countones(rxDrop);
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    nTests++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] st = 4'hf);
    awaddr <= a;
    wdata <= v;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wrResp = bresp;
    bready <= 1'b1;
    @(posedge clock);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rdResp = rresp;
    rready <= 1'b1;
    @(posedge clock);
    rready <= 1'b0;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic testReset();
    check(fullDuplex, 2'b11);
    rd(ADDR_PORT0);
    check(d, CTRL_RESET);
    rd(8'h10);
    check({rdResp, d}, {RESP_SLVERR, 32'h0});
    wr(8'h10, 32'h1);
    check(wrResp, RESP_SLVERR);
    // Alive needs one equipment clock edge after reset first.
    rd(ADDR_STATUS);
    check(d, (32'h3<<STAT_OFFER) | (32'hff<<STAT_RXQL) | 32'h1);
  endtask
  task automatic testSync();
    wr(ADDR_PORT0, 32'h1, 4'h0);
    rd(ADDR_PORT0);
    check(d, 32'h0);
    wr(ADDR_PORT0, 32'h1);
    rd(ADDR_PORT0);
    check(d, 32'h3);
    check({txClkSel[0], clkSrcOffer[0]}, 2'b10);
    wr(ADDR_PORT0, 32'h1);
    rd(ADDR_PORT0);
    check(d, 32'h1);
    check({txClkSel[0], clkSrcOffer[0]}, 2'b11);
    wr(ADDR_STATUS, 32'h0);
    check(wrResp, RESP_OKAY);
    wr(ADDR_PORT0, 32'h6);
    rd(ADDR_PORT0);
    check({d, txClkSel}, 34'h0);
  endtask
  task automatic testPacing();
    wr(ADDR_PORT0, 32'ha7);
    wr(ADDR_PORT1, 32'h57);
    check(esmcTxQl, 8'h5a);
    repeat (3 * PER + 20) @(posedge clock);
    check(u_esmc_peer_model.txCount[0], 3);
    check(u_esmc_peer_model.txCount[1], 3);
    check(u_esmc_peer_model.lastQl[0], 4'ha);
    wr(ADDR_PORT0, 32'h23);
    check(esmcTxQl, 8'h5f);
    wr(ADDR_PORT0, 32'h1);
    s = u_esmc_peer_model.txCount[0];
    repeat (2 * PER) @(posedge clock);
    check(u_esmc_peer_model.txCount[0], s);
    wr(ADDR_PORT0, 32'h3);
    repeat (PER - 5) @(posedge clock);
    check(u_esmc_peer_model.txCount[0], s);
    repeat (25) @(posedge clock);
    check(u_esmc_peer_model.txCount[0], s + 1);
  endtask
  task automatic testShare();
    int g;
    spTxReq <= 1'b1;
    s = takes;
    g = spCnt;
    repeat (PER) @(posedge clock);
    check(takes - s <= SP_MAX_PER_S, 1'b1);
    check(spCnt > g, 1'b1);
    spTxReq <= 1'b0;
    stall <= 1'b1;
    repeat (PER + 20) @(posedge clock);
    check({|esmcTxValid, spTxGrant}, 2'b10);
    stall <= 1'b0;
    check(u_esmc_peer_model.badDst, 1'b0);
  endtask
  task automatic testRx();
    wr(ADDR_PORT1, 32'h0);
    wr(ADDR_DROPS, 32'h0);
    s = drops;
    u_esmc_peer_model.sendFrame(1, 1'b1, 4'h3);
    u_esmc_peer_model.sendFrame(1, 1'b0, 4'h3);
    repeat (2) @(posedge clock);
    check(drops - s, 1);
    rd(ADDR_DROPS);
    check(d, 32'h00010000);
    s = peers;
    u_esmc_peer_model.sendFrame(0, 1'b1, 4'h3);
    repeat (2) @(posedge clock);
    check(peers - s, 1);
    rd(ADDR_STATUS);
    check((d >> STAT_RXQL) & 32'hf, 32'hf);
    wr(ADDR_PORT0, 32'h7);
    u_esmc_peer_model.sendFrame(0, 1'b1, 4'h3);
    repeat (2) @(posedge clock);
    rd(ADDR_STATUS);
    check((d >> STAT_RXQL) & 32'hf, 32'h3);
  endtask
  task automatic testDead();
    clkRun = 1'b0;
    repeat (40) @(posedge clock);
    rd(ADDR_STATUS);
    check(d[STAT_ALIVE], 1'b0);
    clkRun = 1'b1;
    repeat (40) @(posedge clock);
    rd(ADDR_STATUS);
    check(d[STAT_ALIVE], 1'b1);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    testReset();
    testSync();
    testPacing();
    testShare();
    testRx();
    testDead();
    test_done();
  end
endmodule
`default_nettype wire
